// ===== video_in_defs.vh
// Constants for the microdisplay video input front end.
`ifndef VIDEO_IN_DEFS_VH
`define VIDEO_IN_DEFS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define REG_VIDEO_INPUT_CONFIG 8'h01
`define REG_DISPLAY_CONTROL 8'h02
`define REG_HSHIFT 8'h03
`define REG_VSHIFT 8'h04
`define REG_STATUS 8'h05

`define CFG_RESET 8'h04
`define DISP_CTRL_RESET 8'h00
`define SHIFT_RESET 8'h0c
`define SHIFT_MAX 8'h18

// Field positions.
`define CFG_FMT_HI 2
`define CFG_FMT_LO 0
`define CFG_MONO_BIT 3
`define DISP_EN_BIT 0

// ****************************************************************
// Input formats
// ****************************************************************
`define FMT_MONO8 3'h0
`define FMT_YCC422_8 3'h1
`define FMT_YCC422_16 3'h2
`define FMT_YCC444 3'h3
`define FMT_RGB24 3'h4

// ****************************************************************
// Array geometry
// ****************************************************************
`define ACTIVE_COLS 10'h320
`define ACTIVE_ROWS 10'h258

// ****************************************************************
// Colour conversion, coefficients scaled by 256
// ****************************************************************
`define CHROMA_MID 128
`define K_CR_R 359
`define K_CB_G 88
`define K_CR_G 183
`define K_CB_B 454
`define K_SHIFT 8
`define PIX_MAX 255

// ****************************************************************
// Two-wire target
// ****************************************************************
`define TARGET_ADDR_HI 6'h26
`endif

// ===== twowire_target.v
// Two-wire register target with auto-incrementing register pointer.
`timescale 1ns/100ps
`include "video_in_defs.vh"
module twowire_target (
    input wire sys_clk_i,
    input wire rst_i,
    input wire scl_i,
    input wire sda_i,
    input wire addr_lsb_i,
    input wire [7:0] rd_data_i,
    output reg sda_oe_n_o,
    output reg [7:0] reg_addr_o,
    output reg [7:0] wr_data_o,
    output reg wr_en_o
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_AACK = 3'h2;
    localparam ST_WRITE = 3'h3;
    localparam ST_WACK = 3'h4;
    localparam ST_READ = 3'h5;
    localparam ST_RACK = 3'h6;

    reg scl_s1_r, scl_s2_r, scl_d_r;
    reg sda_s1_r, sda_s2_r, sda_d_r;
    reg lsb_s1_r, lsb_s2_r;
    reg [2:0] state_r;
    reg [2:0] cnt_r;
    reg [7:0] shift_r;
    reg ack_on_r;
    reg rd_mode_r;
    reg first_r;
    reg nack_r;
    wire scl_rise = scl_s2_r & ~scl_d_r;
    wire scl_fall = ~scl_s2_r & scl_d_r;
    wire start_w = scl_s2_r & scl_d_r & ~sda_s2_r & sda_d_r;
    wire stop_w = scl_s2_r & scl_d_r & sda_s2_r & ~sda_d_r;
    wire [7:0] shin_w = {shift_r[6:0], sda_s2_r};

    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r <= 1'b1;
            lsb_s1_r <= 1'b0;
            lsb_s2_r <= 1'b0;
        end else begin
            scl_s1_r <= scl_i;
            scl_s2_r <= scl_s1_r;
            scl_d_r <= scl_s2_r;
            sda_s1_r <= sda_i;
            sda_s2_r <= sda_s1_r;
            sda_d_r <= sda_s2_r;
            lsb_s1_r <= addr_lsb_i;
            lsb_s2_r <= lsb_s1_r;
        end
    end

    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            cnt_r <= 3'h0;
            shift_r <= 8'h00;
            ack_on_r <= 1'b0;
            rd_mode_r <= 1'b0;
            first_r <= 1'b0;
            nack_r <= 1'b0;
            sda_oe_n_o <= 1'b1;
            reg_addr_o <= 8'h00;
            wr_data_o <= 8'h00;
            wr_en_o <= 1'b0;
        end else begin
            wr_en_o <= 1'b0;
            if (wr_en_o) begin
                reg_addr_o <= reg_addr_o + 8'h01;
            end
            if (stop_w) begin
                state_r <= ST_IDLE;
                sda_oe_n_o <= 1'b1;
            end else if (start_w) begin
                state_r <= ST_ADDR;
                cnt_r <= 3'h0;
                ack_on_r <= 1'b0;
                sda_oe_n_o <= 1'b1;
            end else begin
                case (state_r)
                    ST_ADDR: begin
                        if (scl_rise) begin
                            shift_r <= shin_w;
                            cnt_r <= cnt_r + 3'h1;
                            if (cnt_r == 3'h7) begin
                                if (shift_r[6:0] == {`TARGET_ADDR_HI, lsb_s2_r}) begin
                                    rd_mode_r <= sda_s2_r;
                                    first_r <= 1'b1;
                                    state_r <= ST_AACK;
                                end else begin
                                    state_r <= ST_IDLE;
                                end
                            end
                        end
                    end
                    ST_AACK, ST_WACK: begin
                        if (scl_fall) begin
                            if (!ack_on_r) begin
                                ack_on_r <= 1'b1;
                                sda_oe_n_o <= 1'b0;
                            end else begin
                                ack_on_r <= 1'b0;
                                cnt_r <= 3'h0;
                                if (rd_mode_r) begin
                                    shift_r <= rd_data_i;
                                    sda_oe_n_o <= rd_data_i[7];
                                    state_r <= ST_READ;
                                end else begin
                                    sda_oe_n_o <= 1'b1;
                                    state_r <= ST_WRITE;
                                end
                            end
                        end
                    end
                    ST_WRITE: begin
                        if (scl_rise) begin
                            shift_r <= shin_w;
                            cnt_r <= cnt_r + 3'h1;
                            if (cnt_r == 3'h7) begin
                                state_r <= ST_WACK;
                                first_r <= 1'b0;
                                if (first_r) begin
                                    reg_addr_o <= shin_w;
                                end else begin
                                    wr_data_o <= shin_w;
                                    wr_en_o <= 1'b1;
                                end
                            end
                        end
                    end
                    ST_READ: begin
                        if (scl_fall) begin
                            if (cnt_r == 3'h7) begin
                                sda_oe_n_o <= 1'b1;
                                reg_addr_o <= reg_addr_o + 8'h01;
                                state_r <= ST_RACK;
                            end else begin
                                shift_r <= {shift_r[6:0], 1'b0};
                                sda_oe_n_o <= shift_r[6];
                                cnt_r <= cnt_r + 3'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            nack_r <= sda_s2_r;
                        end
                        if (scl_fall) begin
                            if (nack_r) begin
                                state_r <= ST_IDLE;
                            end else begin
                                shift_r <= rd_data_i;
                                sda_oe_n_o <= rd_data_i[7];
                                cnt_r <= 3'h0;
                                state_r <= ST_READ;
                            end
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

// ===== video_input_front.v
// Video input front end: format decode, column split, window shift, registers.
// Overview of operation
// - Accept five mono, YCbCr and RGB formats
// - Format chosen by config register 01h field
// - Three 8-bit lanes drive RGB sub-pixels
// - Odd columns top, even columns bottom
// - 824x624 array, 800x600 window shiftable
// - Two-wire target, address LSB from pin
// - Hardware reset blanks display, restores registers
// - Mono: same value in all sub-pixels
// - 256 grey levels per primary colour
`timescale 1ns/100ps
`include "video_in_defs.vh"
module video_input_front (
    input wire sys_clk_i,
    input wire rst_i,
    input wire hard_reset_n_i,
    input wire pixel_clk_in_i,
    input wire hsync_i,
    input wire vsync_i,
    input wire data_en_i,
    input wire [7:0] red_input_lane_i,
    input wire [7:0] green_input_lane_i,
    input wire [7:0] blue_input_lane_i,
    input wire bus_addr_lsb_pin_i,
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output wire sda_oe_n_o,
    output reg disp_on_o,
    output reg top_valid_o,
    output reg bot_valid_o,
    output reg [9:0] array_col_o,
    output reg [9:0] array_row_o,
    output reg [7:0] sub_red_o,
    output reg [7:0] sub_green_o,
    output reg [7:0] sub_blue_o
);
    // Either reset acts at once; release is retimed to the clock.
    wire arst_in = rst_i | ~hard_reset_n_i;
    reg [1:0] rel_r;
    wire arst = rel_r[1];
    always @(posedge sys_clk_i or posedge arst_in) begin
        if (arst_in) rel_r <= 2'h3;
        else rel_r <= {rel_r[0], 1'b0};
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    reg [7:0] cfg_r;
    reg [7:0] disp_ctrl_r;
    reg [7:0] hshift_r;
    reg [7:0] vshift_r;
    reg [7:0] rd_data;
    reg line_active_r;
    reg frame_active_r;
    wire [7:0] reg_addr;
    wire [7:0] wr_data;
    wire wr_en;

    twowire_target u_target (
        .sys_clk_i(sys_clk_i),
        .rst_i(arst),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .addr_lsb_i(bus_addr_lsb_pin_i),
        .rd_data_i(rd_data),
        .sda_oe_n_o(sda_oe_n_o),
        .reg_addr_o(reg_addr),
        .wr_data_o(wr_data),
        .wr_en_o(wr_en)
    );

    always @(posedge sys_clk_i or posedge arst) begin
        if (arst) begin
            cfg_r <= `CFG_RESET;
            disp_ctrl_r <= `DISP_CTRL_RESET;
            hshift_r <= `SHIFT_RESET;
            vshift_r <= `SHIFT_RESET;
            sda_o <= 1'b0;
        end else if (wr_en) begin
            case (reg_addr)
                `REG_VIDEO_INPUT_CONFIG: cfg_r <= wr_data;
                `REG_DISPLAY_CONTROL: disp_ctrl_r <= wr_data;
                // Shift limited to the spare 24.
                `REG_HSHIFT: hshift_r <= (wr_data > `SHIFT_MAX) ? `SHIFT_MAX : wr_data;
                `REG_VSHIFT: vshift_r <= (wr_data > `SHIFT_MAX) ? `SHIFT_MAX : wr_data;
                default: cfg_r <= cfg_r;
            endcase
        end
    end

    always @* begin
        case (reg_addr)
            `REG_VIDEO_INPUT_CONFIG: rd_data = cfg_r;
            `REG_DISPLAY_CONTROL: rd_data = disp_ctrl_r;
            `REG_HSHIFT: rd_data = hshift_r;
            `REG_VSHIFT: rd_data = vshift_r;
            `REG_STATUS: rd_data = {5'h00, frame_active_r, line_active_r, disp_on_o};
            default: rd_data = 8'h00;
        endcase
    end

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    // The pixel clock is oversampled, so it must stay below a quarter of
    // the system clock; faster sources need a real second clock domain.
    reg [26:0] in_s1_r;
    reg [26:0] in_s2_r;
    reg pclk_d_r;
    reg de_d_r;
    reg vs_d_r;
    wire pclk_s = in_s2_r[26];
    wire de_s = in_s2_r[25];
    wire vs_s = in_s2_r[24];
    wire [7:0] lane_r = in_s2_r[23:16];
    wire [7:0] lane_g = in_s2_r[15:8];
    wire [7:0] lane_b = in_s2_r[7:0];

    // Timing derived from source clock, data enable and vsync.
    always @(posedge sys_clk_i or posedge arst) begin
        if (arst) begin
            in_s1_r <= 27'h0000000;
            in_s2_r <= 27'h0000000;
            pclk_d_r <= 1'b0;
            de_d_r <= 1'b0;
            vs_d_r <= 1'b0;
        end else begin
            in_s1_r <= {pixel_clk_in_i, data_en_i, vsync_i, red_input_lane_i,
                green_input_lane_i, blue_input_lane_i};
            in_s2_r <= in_s1_r;
            pclk_d_r <= pclk_s;
            de_d_r <= de_s;
            vs_d_r <= vs_s;
        end
    end

    wire pclk_rise = pclk_s & ~pclk_d_r;
    // Sample only while data enable is high.
    wire accept = pclk_rise & de_s;
    wire line_end = de_d_r & ~de_s;
    wire frame_start = vs_s & ~vs_d_r;

    // ****************************************************************
    // Format decode
    // ****************************************************************
    reg [9:0] col_r;
    reg [9:0] row_r;
    reg [1:0] phase_r;
    reg [7:0] cb_hold_r;
    reg [7:0] cr_hold_r;
    reg emit;
    reg use_ycc;
    reg [7:0] y_v;
    reg [7:0] cb_v;
    reg [7:0] cr_v;
    wire [2:0] fmt = cfg_r[`CFG_FMT_HI:`CFG_FMT_LO];

    // Pick luma, chroma and pixel strobe per format.
    always @* begin
        emit = accept;
        use_ycc = 1'b1;
        y_v = lane_g;
        cb_v = lane_b;
        cr_v = lane_r;
        case (fmt)
            `FMT_YCC422_8: begin
                emit = accept & phase_r[0];
                cb_v = cb_hold_r;
                cr_v = cr_hold_r;
            end
            `FMT_YCC422_16: begin
                cb_v = col_r[0] ? cb_hold_r : lane_b;
                cr_v = col_r[0] ? lane_b : cr_hold_r;
            end
            `FMT_YCC444: use_ycc = 1'b1;
            default: use_ycc = 1'b0;
        endcase
    end

    // Full 8-bit range per primary, clamped.
    function [7:0] clamp8;
        input integer v;
        begin
            if (v < 0) begin
                clamp8 = 8'h00;
            end else if (v > `PIX_MAX) begin
                clamp8 = 8'hff;
            end else begin
                clamp8 = v[7:0];
            end
        end
    endfunction

    // Signed luma keeps negative chroma terms from wrapping before the clamp.
    integer yo, cbo, cro;
    reg [7:0] red_v, grn_v, blu_v;

    always @* begin
        yo = {24'h000000, y_v};
        cbo = cb_v - `CHROMA_MID;
        cro = cr_v - `CHROMA_MID;
        if (cfg_r[`CFG_MONO_BIT] || fmt == `FMT_MONO8) begin
            // Same value in all three sub-pixels.
            red_v = y_v;
            grn_v = y_v;
            blu_v = y_v;
        end else if (use_ycc) begin
            red_v = clamp8(yo + ((`K_CR_R * cro) >>> `K_SHIFT));
            grn_v = clamp8(yo - ((`K_CB_G * cbo + `K_CR_G * cro) >>> `K_SHIFT));
            blu_v = clamp8(yo + ((`K_CB_B * cbo) >>> `K_SHIFT));
        end else begin
            // Each lane drives its own sub-pixel.
            red_v = lane_r;
            grn_v = lane_g;
            blu_v = lane_b;
        end
    end

    // ****************************************************************
    // Counters and array write
    // ****************************************************************
    wire [9:0] col_pos = col_r + {2'h0, hshift_r};
    wire [9:0] row_pos = row_r + {2'h0, vshift_r};
    wire in_window = (col_r < `ACTIVE_COLS) && (row_r < `ACTIVE_ROWS);

    always @(posedge sys_clk_i or posedge arst) begin
        if (arst) begin
            col_r <= 10'h000;
            row_r <= 10'h000;
            phase_r <= 2'h0;
            cb_hold_r <= 8'h80;
            cr_hold_r <= 8'h80;
            line_active_r <= 1'b0;
            frame_active_r <= 1'b0;
            disp_on_o <= 1'b0;
            top_valid_o <= 1'b0;
            bot_valid_o <= 1'b0;
            array_col_o <= 10'h000;
            array_row_o <= 10'h000;
            sub_red_o <= 8'h00;
            sub_green_o <= 8'h00;
            sub_blue_o <= 8'h00;
        end else begin
            // Dark until software sets the enable bit.
            disp_on_o <= disp_ctrl_r[`DISP_EN_BIT];
            line_active_r <= de_s;
            top_valid_o <= 1'b0;
            bot_valid_o <= 1'b0;
            if (frame_start) begin
                row_r <= 10'h000;
                col_r <= 10'h000;
                phase_r <= 2'h0;
                frame_active_r <= 1'b1;
            end else if (line_end) begin
                row_r <= row_r + 10'h001;
                col_r <= 10'h000;
                phase_r <= 2'h0;
            end else if (accept) begin
                phase_r <= phase_r + 2'h1;
                if (fmt == `FMT_YCC422_8 && phase_r == 2'h0) begin
                    cb_hold_r <= lane_g;
                end
                if (fmt == `FMT_YCC422_8 && phase_r == 2'h2) begin
                    cr_hold_r <= lane_g;
                end
                if (fmt == `FMT_YCC422_16) begin
                    if (col_r[0]) begin
                        cr_hold_r <= lane_b;
                    end else begin
                        cb_hold_r <= lane_b;
                    end
                end
                if (emit) begin
                    col_r <= col_r + 10'h001;
                    if (in_window && disp_on_o) begin
                        // Odd column to top, even to bottom.
                        top_valid_o <= col_pos[0];
                        bot_valid_o <= ~col_pos[0];
                        array_col_o <= col_pos;
                        array_row_o <= row_pos;
                        sub_red_o <= red_v;
                        sub_green_o <= grn_v;
                        sub_blue_o <= blu_v;
                    end
                end
            end
        end
    end
endmodule

// ===== video_src_model.sv
// Behavioural video source for the pixel side of the front end.
`timescale 1ns/100ps
module video_src_model (
    input wire sys_clk_i,
    output logic pclk_o,
    output logic hs_o,
    output logic vs_o,
    output logic de_o,
    output logic [7:0] r_o,
    output logic [7:0] g_o,
    output logic [7:0] b_o
);
    initial {pclk_o, hs_o, vs_o, de_o, r_o, g_o, b_o} = 28'h0;
    task wt(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    // source clock data
    // The pixel clock only toggles here, so it stands still between pixels.
    // Codes go out untouched, as gamma corrected values chosen by the caller.
    task pix(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b, input logic en);
        r_o = r;
        g_o = g;
        b_o = b;
        de_o = en;
        wt(4);
        pclk_o = 1'b1;
        wt(4);
        pclk_o = 1'b0;
    endtask
    // line end
    // Lanes show the inverse of the last value once data enable drops.
    task eol;
        de_o = 1'b0;
        {r_o, g_o, b_o} = ~{r_o, g_o, b_o};
        hs_o = 1'b1;
        wt(8);
        hs_o = 1'b0;
        wt(4);
    endtask
    task frame;
        vs_o = 1'b1;
        wt(8);
        vs_o = 1'b0;
        wt(8);
    endtask
endmodule

// ===== video_in_asserts.sv
// Concurrent checks on the ports of the video input front end.
`timescale 1ns/100ps
module video_in_asserts (
    input wire sys_clk_i,
    input wire rst_i,
    input wire hard_reset_n_i,
    input wire data_en_i,
    input wire scl_i,
    input wire sda_oe_n_o,
    input wire disp_on_o,
    input wire top_valid_o,
    input wire bot_valid_o,
    input wire [9:0] array_col_o,
    input wire [9:0] array_row_o
);
    wire pix_w = top_valid_o | bot_valid_o;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    side_excl_a: assert property (!(top_valid_o && bot_valid_o))
        else $error("both sequencer sides valid");
    top_odd_a: assert property (top_valid_o |-> array_col_o[0])
        else $error("top side on even column");
    bot_even_a: assert property (bot_valid_o |-> !array_col_o[0])
        else $error("bottom side on odd column");
    pulse_once_a: assert property (pix_w |=> !pix_w)
        else $error("pixel strobe longer than one cycle");
    col_bound_a: assert property (pix_w |-> array_col_o < 10'h338)
        else $error("column beyond array");
    row_bound_a: assert property (pix_w |-> array_row_o < 10'h270)
        else $error("row beyond array");
    dark_quiet_a: assert property (!disp_on_o |-> !pix_w)
        else $error("pixel written while dark");
    hard_off_a: assert property (!hard_reset_n_i |-> !disp_on_o && !pix_w)
        else $error("display on during hardware reset");
    de_gate_a: assert property (pix_w |-> $past(data_en_i, 3) || $past(data_en_i, 4))
        else $error("pixel taken outside data enable");
    sda_low_a: assert property ($changed(sda_oe_n_o) |-> !scl_i)
        else $error("data line moved while clock high");
endmodule
bind video_input_front video_in_asserts u_chk (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .hard_reset_n_i(hard_reset_n_i),
    .data_en_i(data_en_i),
    .scl_i(scl_i),
    .sda_oe_n_o(sda_oe_n_o),
    .disp_on_o(disp_on_o),
    .top_valid_o(top_valid_o),
    .bot_valid_o(bot_valid_o),
    .array_col_o(array_col_o),
    .array_row_o(array_row_o)
);

// ===== tb.sv
// Self-checking bench for the video input front end.
`timescale 1ns/100ps
`include "video_in_defs.vh"
module tb;
    logic sys_clk_i = 0;
    logic rst_i = 1;
    logic hrst_n = 1;
    logic lsb = 0;
    logic scl_m = 1;
    logic sda_m = 1;
    wire pclk, hs, vs, de, sda_o, sda_oe_n, disp_on, top_v, bot_v;
    wire [7:0] r, g, b, sr, sg, sb;
    wire [9:0] col, row;
    // Open drain with pull-up: low when either party pulls.
    wire sda_w = sda_m & (sda_oe_n | sda_o);
    int err_total = 0;
    int tests_run = 0;
    logic [44:0] q[$];
    always #25 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (top_v | bot_v) q.push_back({top_v, col, row, sr, sg, sb});
    video_src_model i_src (.sys_clk_i(sys_clk_i), .pclk_o(pclk), .hs_o(hs), .vs_o(vs),
        .de_o(de), .r_o(r), .g_o(g), .b_o(b));
    video_input_front i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .hard_reset_n_i(hrst_n),
        .pixel_clk_in_i(pclk), .hsync_i(hs), .vsync_i(vs), .data_en_i(de),
        .red_input_lane_i(r), .green_input_lane_i(g), .blue_input_lane_i(b),
        .bus_addr_lsb_pin_i(lsb), .scl_i(scl_m), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n), .disp_on_o(disp_on), .top_valid_o(top_v),
        .bot_valid_o(bot_v), .array_col_o(col), .array_row_o(row),
        .sub_red_o(sr), .sub_green_o(sg), .sub_blue_o(sb));
    task cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task chkp(input logic [44:0] exp);
        tests_run++;
        if (q.size() == 0 || q[0] !== exp) begin
            err_total++;
            $display("BAD %0t pixel missing or wrong, expected %h", $time, exp);
        end
        if (q.size() != 0) void'(q.pop_front());
    endtask
    // ****************************************************************
    // Two-wire bus master
    // ****************************************************************
    task bw(input logic v);
        sda_m = v;
        cyc(4);
        scl_m = 1;
        cyc(8);
        scl_m = 0;
        cyc(4);
    endtask
    task br(output logic v);
        sda_m = 1;
        cyc(4);
        scl_m = 1;
        cyc(4);
        v = sda_w;
        cyc(4);
        scl_m = 0;
        cyc(4);
    endtask
    task st;
        sda_m = 1;
        cyc(4);
        scl_m = 1;
        cyc(8);
        sda_m = 0;
        cyc(8);
        scl_m = 0;
        cyc(4);
    endtask
    task sp;
        sda_m = 0;
        cyc(4);
        scl_m = 1;
        cyc(8);
        sda_m = 1;
        cyc(8);
    endtask
    task wb(input logic [7:0] d, output logic a);
        for (int i = 7; i >= 0; i--) bw(d[i]);
        br(a);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic k;
        st;
        wb({`TARGET_ADDR_HI, lsb, 1'b0}, k);
        chk8({7'h0, k}, 8'h00);
        wb(a, k);
        wb(d, k);
        sp;
    endtask
    task rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic k;
        logic [7:0] d;
        st;
        wb({`TARGET_ADDR_HI, lsb, 1'b0}, k);
        wb(a, k);
        st;
        wb({`TARGET_ADDR_HI, lsb, 1'b1}, k);
        for (int i = 7; i >= 0; i--) br(d[i]);
        bw(1'b1);
        sp;
        chk8(d, exp);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_regs;
        rdchk(`REG_VIDEO_INPUT_CONFIG, `CFG_RESET);
        rdchk(`REG_DISPLAY_CONTROL, `DISP_CTRL_RESET);
        rdchk(`REG_HSHIFT, `SHIFT_RESET);
        rdchk(8'h10, 8'h00);
        $display("test regs done");
    endtask
    task t_addr;
        logic k;
        lsb = 1;
        cyc(4);
        st;
        wb({`TARGET_ADDR_HI, 1'b0, 1'b0}, k);
        chk8({7'h0, k}, 8'h01);
        sp;
        rdchk(`REG_VSHIFT, `SHIFT_RESET);
        $display("test addr done");
    endtask
    task t_dark;
        i_src.frame;
        i_src.pix(8'h10, 8'h20, 8'h30, 1'b1);
        i_src.eol;
        chk8(8'(q.size()), 8'h00);
        wr(`REG_DISPLAY_CONTROL, 8'h01);
        cyc(4);
        chk8({7'h0, disp_on}, 8'h01);
        $display("test dark done");
    endtask
    // Neutral chroma keeps every YCbCr result equal to luma, so the
    // conversion rounding does not enter the expectation.
    task t_fmt;
        logic [7:0] y0, y1;
        for (int f = 0; f < 6; f++) begin
            y0 = (f < 4) ? 8'hff : 8'h34;
            y1 = 8'h00;
            wr(`REG_VIDEO_INPUT_CONFIG, (f == 5) ? 8'h0c : 8'(f));
            i_src.frame;
            if (f == 1) i_src.pix(8'h5a, 8'h80, 8'ha5, 1'b1);
            i_src.pix((f == 3) ? 8'h80 : 8'h12, y0, (f > 1) ? 8'h80 : 8'h56, 1'b1);
            if (f == 1) i_src.pix(8'h5a, 8'h80, 8'ha5, 1'b1);
            i_src.pix((f == 3) ? 8'h80 : 8'h9a, y1, (f > 1) ? 8'h80 : 8'hbc, 1'b1);
            i_src.eol;
            if (f == 4) begin
                chkp({1'b0, 10'd12, 10'd12, 8'h12, y0, 8'h80});
                chkp({1'b1, 10'd13, 10'd12, 8'h9a, y1, 8'h80});
            end else begin
                chkp({1'b0, 10'd12, 10'd12, y0, y0, y0});
                chkp({1'b1, 10'd13, 10'd12, y1, y1, y1});
            end
        end
        $display("test formats done");
    endtask
    task t_shift;
        wr(`REG_HSHIFT, 8'h1e);
        rdchk(`REG_HSHIFT, `SHIFT_MAX);
        wr(`REG_HSHIFT, 8'h00);
        wr(`REG_VSHIFT, `SHIFT_MAX);
        i_src.frame;
        i_src.pix(8'h01, 8'h01, 8'h01, 1'b0);
        i_src.pix(8'h02, 8'h02, 8'h02, 1'b1);
        i_src.eol;
        i_src.pix(8'hfe, 8'hfe, 8'hfe, 1'b1);
        i_src.eol;
        chkp({1'b0, 10'd0, 10'd24, 8'h02, 8'h02, 8'h02});
        chkp({1'b0, 10'd0, 10'd25, 8'hfe, 8'hfe, 8'hfe});
        chk8(8'(q.size()), 8'h00);
        $display("test shift done");
    endtask
    task t_hrst;
        hrst_n = 0;
        cyc(3);
        chk8({7'h0, disp_on}, 8'h00);
        hrst_n = 1;
        cyc(4);
        rdchk(`REG_DISPLAY_CONTROL, `DISP_CTRL_RESET);
        rdchk(`REG_VSHIFT, `SHIFT_RESET);
        $display("test hard reset done");
    endtask
    task print_verdict;
        $display("tests %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        cyc(6);
        rst_i = 0;
        cyc(4);
        t_regs;
        t_addr;
        t_dark;
        t_fmt;
        t_shift;
        t_hrst;
        print_verdict;
    end
    // The run needs about 10500 cycles; this allows well over twice that.
    initial begin
        #2000000;
        err_total++;
        $display("BAD %0t watchdog expired", $time);
        print_verdict;
    end
endmodule
